// file: cluster_node.sv
// processor end of the cluster bus: master requests and snoop service
`timescale 1ns/1ps
// How it works
// [R1] two to four nodes share one bus
// [R2] coordinator grants using request, grant, release
// [R3] master requests mapped to external request kinds
// [R4] coherent reads seen as interventions
// [R5] master data response seen as block data
// [R6] targeted requests served in order, state each
// [R7] dirty hit adds data response after state
// [R8] coordinator grants bus to the dirty owner
// [R9] ack after data frees request number
// [R10] upgrade without owner acked, number freed
// [R11] target mode makes peers snoop coherent requests
// [R12] at most one node granted at once
module cluster_node import cluster_pkg::*; #(
	parameter int NPROC = MAX_PROC,
	parameter int ID = 0,
	parameter int QDEPTH = QDEPTH_DEF
) (
	input wire logic clk,
	input wire logic nrst,
	cluster_bus_if.node bus,
	input wire logic coherent_request_target_mode,
	input wire logic req_valid,
	input wire proc_op_t req_op,
	input wire logic [AD_W-1:0] req_addr,
	output logic req_taken,
	output logic req_done,
	output logic [RN_W-1:0] done_num,
	output logic observe_valid,
	output ext_op_t observe_op,
	output logic [AD_W-1:0] observe_addr,
	output logic blk_data_valid,
	output logic [AD_W-1:0] blk_data,
	output logic lookup_valid,
	output ext_op_t lookup_op,
	output logic [AD_W-1:0] lookup_addr,
	input wire logic lookup_done,
	input wire state_t lookup_state,
	input wire logic [AD_W-1:0] lookup_data,
	output logic queue_full
);
	localparam int QW = $clog2(QDEPTH);
	localparam logic [ID_W-1:0] MY_ID = ID_W'(ID);

	typedef enum logic [1:0] {M_IDLE, M_WAIT} mst_t;
	typedef enum logic [1:0] {S_IDLE, S_LOOK, S_DATA} snp_t;

	// snoop queue kept here; depth only bounds back-to-back requests
	ext_op_t q_op [QDEPTH];
	logic [AD_W-1:0] q_ad [QDEPTH];

	mst_t mst_r, mst_nxt;
	snp_t snp_r, snp_nxt;
	proc_op_t mop_r, mop_nxt;
	logic [AD_W-1:0] mad_r, mad_nxt, dat_r, dat_nxt;
	logic [RN_W-1:0] mrn_r, mrn_nxt;
	logic [NUM_RN-1:0] busy_r, busy_nxt;
	logic [QW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
	logic [QW:0] cnt_r, cnt_nxt;
	logic req_n_r, req_n_nxt, oe_r, oe_nxt, sv_n_r, sv_n_nxt;
	logic full_r, full_nxt;
	logic [CMD_W-1:0] cmd_r, cmd_nxt;
	logic [AD_W-1:0] ad_r, ad_nxt;
	state_t st_r, st_nxt;
	logic taken_r, taken_nxt, done_r, done_nxt;
	logic [RN_W-1:0] dnum_r, dnum_nxt;
	logic obs_r, obs_nxt, bdv_r, bdv_nxt, lkv_r, lkv_nxt;
	ext_op_t obs_op_r, obs_op_nxt, lk_op_r, lk_op_nxt;
	logic [AD_W-1:0] obs_ad_r, obs_ad_nxt, bd_r, bd_nxt;
	logic [AD_W-1:0] lk_ad_r, lk_ad_nxt;
	logic push, pop, free_f, granted, seen;
	logic [RN_W-1:0] free_rn;
	ext_op_t seen_x;

	// bus pins
	assign bus.bus_request_n[ID] = req_n_r; // [R2]
	assign bus.cmd_out[ID] = cmd_r;
	assign bus.ad_out[ID] = ad_r;
	assign bus.cmd_oe[ID] = oe_r;
	assign bus.state_out[ID] = st_r;
	assign bus.state_val_n[ID] = sv_n_r;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		mst_nxt = mst_r;
		snp_nxt = snp_r;
		mop_nxt = mop_r;
		mad_nxt = mad_r;
		mrn_nxt = mrn_r;
		dat_nxt = dat_r;
		busy_nxt = busy_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		cnt_nxt = cnt_r;
		oe_nxt = 1'b0;
		cmd_nxt = '0;
		ad_nxt = '0;
		sv_n_nxt = 1'b1;
		st_nxt = st_r;
		taken_nxt = 1'b0;
		done_nxt = 1'b0;
		dnum_nxt = dnum_r;
		obs_nxt = 1'b0;
		obs_op_nxt = obs_op_r;
		obs_ad_nxt = obs_ad_r;
		bdv_nxt = 1'b0;
		bd_nxt = bd_r;
		lkv_nxt = lkv_r;
		lk_op_nxt = lk_op_r;
		lk_ad_nxt = lk_ad_r;
		push = 1'b0;
		pop = 1'b0;
		free_f = 1'b0;
		free_rn = '0;
		for (int n = NUM_RN - 1; n >= 0; n--) begin
			if (!busy_r[n]) begin
				free_f = 1'b1;
				free_rn = RN_W'(n);
			end
		end
		// grant holds until the coordinator sees our cycle
		granted = !bus.bus_grant_n[ID] && !oe_r; // [R12]
		seen = !bus.bus_valid_n && cmd_src(bus.system_command) != MY_ID;
		seen_x = to_ext(cmd_op(bus.system_command)); // [R3] [R4]

		// other masters' traffic
		if (seen && seen_x == XR_BLK_DATA) begin
			bdv_nxt = 1'b1; // [R5]
			bd_nxt = bus.system_addr_data;
		end else if (seen) begin
			obs_nxt = 1'b1;
			obs_op_nxt = seen_x;
			obs_ad_nxt = bus.system_addr_data;
			push = coherent_request_target_mode && is_coh(seen_x); // [R11]
		end

		// completion frees our request number
		if (!bus.resp_val_n && bus.resp[RSP_ID_LSB +: ID_W] == MY_ID
			&& bus.resp[1:0] == RSP_ACK) begin
			busy_nxt[bus.resp[RSP_RN_LSB +: RN_W]] = 1'b0; // [R9] [R10]
			done_nxt = 1'b1;
			dnum_nxt = bus.resp[RSP_RN_LSB +: RN_W];
		end

		// snoop service, oldest first
		unique case (snp_r)
			S_IDLE: begin
				if (cnt_r != '0) begin
					lkv_nxt = 1'b1; // [R6]
					lk_op_nxt = q_op[rd_r];
					lk_ad_nxt = q_ad[rd_r];
					snp_nxt = S_LOOK;
				end
			end
			S_LOOK: begin
				if (lookup_done) begin
					lkv_nxt = 1'b0;
					sv_n_nxt = 1'b0; // [R6]
					st_nxt = lookup_state;
					pop = 1'b1;
					if (lookup_state == modified_owned_state) begin
						dat_nxt = lookup_data; // [R7]
						snp_nxt = S_DATA;
					end else begin
						snp_nxt = S_IDLE;
					end
				end
			end
			S_DATA: begin
				if (granted) begin
					oe_nxt = 1'b1; // [R7] [R8]
					cmd_nxt = mk_cmd(PR_DATA, '0, MY_ID);
					ad_nxt = dat_r;
					snp_nxt = S_IDLE;
				end
			end
			default: snp_nxt = S_IDLE;
		endcase

		// own requests; a pending data response uses the grant first
		unique case (mst_r)
			M_IDLE: begin
				if (req_valid && free_f) begin
					taken_nxt = 1'b1;
					mop_nxt = req_op;
					mad_nxt = req_addr;
					mrn_nxt = free_rn;
					busy_nxt[free_rn] = 1'b1;
					mst_nxt = M_WAIT;
				end
			end
			M_WAIT: begin
				if (granted && snp_r != S_DATA) begin
					oe_nxt = 1'b1;
					cmd_nxt = mk_cmd(mop_r, mrn_r, MY_ID);
					ad_nxt = mad_r;
					mst_nxt = M_IDLE;
				end
			end
			default: mst_nxt = M_IDLE;
		endcase
		req_n_nxt = !(mst_nxt == M_WAIT); // [R2]

		// full queue drops the newest; coordinator must pace interventions
		if (push && !full_r) begin
			wr_nxt = QW'((32'(wr_r) + 1) % QDEPTH);
		end else begin
			push = 1'b0;
		end
		if (pop) begin
			rd_nxt = QW'((32'(rd_r) + 1) % QDEPTH);
		end
		cnt_nxt = cnt_r + (QW+1)'(push) - (QW+1)'(pop);
		// count is one bit wider than the pointers so a full queue shows
		full_nxt = (cnt_nxt == (QW+1)'(QDEPTH));
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (push) begin
			q_op[wr_r] <= seen_x; // [R6]
			q_ad[wr_r] <= bus.system_addr_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mst_r <= M_IDLE;
			snp_r <= S_IDLE;
			mop_r <= PR_NONE;
			mad_r <= '0;
			mrn_r <= '0;
			dat_r <= '0;
			busy_r <= '0;
			rd_r <= '0;
			wr_r <= '0;
			cnt_r <= '0;
			req_n_r <= 1'b1;
			oe_r <= 1'b0;
			cmd_r <= '0;
			ad_r <= '0;
			sv_n_r <= 1'b1;
			st_r <= ST_INVALID;
			taken_r <= 1'b0;
			done_r <= 1'b0;
			dnum_r <= '0;
			obs_r <= 1'b0;
			obs_op_r <= XR_NOP;
			obs_ad_r <= '0;
			bdv_r <= 1'b0;
			bd_r <= '0;
			lkv_r <= 1'b0;
			lk_op_r <= XR_NOP;
			lk_ad_r <= '0;
			full_r <= 1'b0;
		end else begin
			mst_r <= mst_nxt;
			snp_r <= snp_nxt;
			mop_r <= mop_nxt;
			mad_r <= mad_nxt;
			mrn_r <= mrn_nxt;
			dat_r <= dat_nxt;
			busy_r <= busy_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			cnt_r <= cnt_nxt;
			req_n_r <= req_n_nxt;
			oe_r <= oe_nxt;
			cmd_r <= cmd_nxt;
			ad_r <= ad_nxt;
			sv_n_r <= sv_n_nxt;
			st_r <= st_nxt;
			taken_r <= taken_nxt;
			done_r <= done_nxt;
			dnum_r <= dnum_nxt;
			obs_r <= obs_nxt;
			obs_op_r <= obs_op_nxt;
			obs_ad_r <= obs_ad_nxt;
			bdv_r <= bdv_nxt;
			bd_r <= bd_nxt;
			lkv_r <= lkv_nxt;
			lk_op_r <= lk_op_nxt;
			lk_ad_r <= lk_ad_nxt;
			full_r <= full_nxt;
		end
	end

	assign req_taken = taken_r;
	assign req_done = done_r;
	assign done_num = dnum_r;
	assign observe_valid = obs_r;
	assign observe_op = obs_op_r;
	assign observe_addr = obs_ad_r;
	assign blk_data_valid = bdv_r;
	assign blk_data = bd_r;
	assign lookup_valid = lkv_r;
	assign lookup_op = lk_op_r;
	assign lookup_addr = lk_ad_r;
	assign queue_full = full_r;
endmodule // cluster_node

// file: cluster_pkg.sv
// shared constants, types and field helpers of the cluster bus
package cluster_pkg;
	localparam int MIN_PROC = 2;
	localparam int MAX_PROC = 4;
	localparam int ID_W = 2;
	localparam int CMD_W = 12;
	localparam int AD_W = 64;
	localparam int RN_W = 3;
	localparam int NUM_RN = 8;
	localparam int ST_W = 2;
	localparam int RSP_W = 7;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_RN_LSB = 4;
	localparam int CMD_SRC_LSB = 8;
	localparam int RSP_RN_LSB = 2;
	localparam int RSP_ID_LSB = 5;
	localparam logic [1:0] RSP_ACK = 2'h1;
	localparam int QDEPTH_DEF = 4;

	typedef enum logic [3:0] {PR_NONE, PR_RD_SHD, PR_RD_EXC, PR_RD_NC,
		PR_RD_WORD, PR_WR_BLK, PR_WR_WORD, PR_UPGRADE, PR_ELIM,
		PR_DATA} proc_op_t;
	typedef enum logic [2:0] {XR_NOP, XR_INT_SHD, XR_INT_EXC, XR_ALLOC,
		XR_INVAL, XR_BLK_DATA} ext_op_t;
	typedef enum logic [ST_W-1:0] {ST_INVALID, ST_SHARED, ST_CLEAN_EXCL,
		modified_owned_state} state_t;

	// how a slave sees the master's request
	function automatic ext_op_t to_ext(input proc_op_t op);
		unique case (op)
			PR_RD_SHD: to_ext = XR_INT_SHD;
			PR_RD_EXC: to_ext = XR_INT_EXC;
			PR_RD_NC, PR_RD_WORD: to_ext = XR_ALLOC;
			PR_UPGRADE: to_ext = XR_INVAL;
			PR_DATA: to_ext = XR_BLK_DATA;
			default: to_ext = XR_NOP;
		endcase
	endfunction

	function automatic logic is_coh(input ext_op_t x);
		is_coh = (x == XR_INT_SHD) || (x == XR_INT_EXC) || (x == XR_INVAL);
	endfunction

	function automatic logic [CMD_W-1:0] mk_cmd(input proc_op_t op,
		input logic [RN_W-1:0] rn, input logic [ID_W-1:0] src);
		mk_cmd = '0;
		mk_cmd[CMD_OP_LSB +: 4] = op;
		mk_cmd[CMD_RN_LSB +: RN_W] = rn;
		mk_cmd[CMD_SRC_LSB +: ID_W] = src;
	endfunction

	function automatic proc_op_t cmd_op(input logic [CMD_W-1:0] c);
		cmd_op = proc_op_t'(c[CMD_OP_LSB +: 4]);
	endfunction

	function automatic logic [RN_W-1:0] cmd_rn(input logic [CMD_W-1:0] c);
		cmd_rn = c[CMD_RN_LSB +: RN_W];
	endfunction

	function automatic logic [ID_W-1:0] cmd_src(input logic [CMD_W-1:0] c);
		cmd_src = c[CMD_SRC_LSB +: ID_W];
	endfunction
endpackage

// file: cluster_bus_if.sv
// shared cluster bus between processor nodes and the coordinator
`timescale 1ns/1ps
interface cluster_bus_if import cluster_pkg::*; #(
	parameter int NPROC = MAX_PROC
) (
	input wire logic clk
);
	wire [NPROC-1:0] bus_request_n;
	logic [NPROC-1:0] bus_grant_n;
	logic bus_release_n;
	wire [CMD_W-1:0] cmd_out [NPROC];
	wire [AD_W-1:0] ad_out [NPROC];
	wire [NPROC-1:0] cmd_oe;
	wire [ST_W-1:0] state_out [NPROC];
	wire [NPROC-1:0] state_val_n;
	logic [RSP_W-1:0] resp;
	logic resp_val_n;
	logic [CMD_W-1:0] system_command;
	logic [AD_W-1:0] system_addr_data;
	logic bus_valid_n;

	// wired bus: whoever enables drives, idle reads as zero
	always_comb begin
		system_command = '0;
		system_addr_data = '0;
		for (int p = 0; p < NPROC; p++) begin
			if (cmd_oe[p]) begin
				system_command = system_command | cmd_out[p];
				system_addr_data = system_addr_data | ad_out[p];
			end
		end
		bus_valid_n = ~|cmd_oe;
	end

	modport node (output bus_request_n, cmd_out, ad_out, cmd_oe,
		state_out, state_val_n, input bus_grant_n, bus_release_n, resp,
		resp_val_n, system_command, system_addr_data, bus_valid_n);
	modport coord (input bus_request_n, state_out, state_val_n,
		system_command, system_addr_data, bus_valid_n,
		output bus_grant_n, bus_release_n, resp, resp_val_n);
endinterface // cluster_bus_if

// file: cluster_coordinator.sv
// coordinator end: arbitration, state collection and completions
`timescale 1ns/1ps
module cluster_coordinator import cluster_pkg::*; #(
	parameter int NPROC = MAX_PROC
) (
	input wire logic clk,
	input wire logic nrst,
	cluster_bus_if.coord bus,
	input wire logic snoop_mode,
	output logic busy,
	output logic [ID_W-1:0] master_id
);
	// a cluster outside two to four nodes simply grants nobody
	localparam logic LEGAL = (NPROC >= MIN_PROC) && (NPROC <= MAX_PROC); // [R1]

	typedef enum logic [2:0] {C_IDLE, C_GRANT, C_COLLECT, C_DATA,
		C_ACK} crd_t;

	crd_t c_r, c_nxt;
	logic [NPROC-1:0] gnt_n_r, gnt_n_nxt, got_r, got_nxt;
	logic [ID_W-1:0] mst_r, mst_nxt, rr_r, rr_nxt, own_r, own_nxt;
	logic own_f_r, own_f_nxt, rel_n_r, rel_n_nxt, rv_n_r, rv_n_nxt;
	logic [RN_W-1:0] rn_r, rn_nxt;
	logic [RSP_W-1:0] rsp_r, rsp_nxt;
	logic pick_f;
	logic busy_r, busy_nxt;
	logic [ID_W-1:0] pick;
	int idx;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		c_nxt = c_r;
		gnt_n_nxt = gnt_n_r;
		got_nxt = got_r;
		mst_nxt = mst_r;
		rr_nxt = rr_r;
		own_nxt = own_r;
		own_f_nxt = own_f_r;
		rn_nxt = rn_r;
		rel_n_nxt = 1'b1;
		rv_n_nxt = 1'b1;
		rsp_nxt = rsp_r;
		pick_f = 1'b0;
		pick = '0;
		idx = 0;
		// round robin starting after the last master
		for (int k = NPROC; k >= 1; k--) begin
			idx = (32'(rr_r) + k) % NPROC;
			if (!bus.bus_request_n[idx]) begin
				pick_f = 1'b1;
				pick = ID_W'(idx);
			end
		end
		unique case (c_r)
			C_IDLE: begin
				if (pick_f && LEGAL) begin
					gnt_n_nxt = '1;
					gnt_n_nxt[pick] = 1'b0; // [R2] [R12]
					mst_nxt = pick;
					rr_nxt = pick;
					c_nxt = C_GRANT;
				end
			end
			C_GRANT: begin
				if (!bus.bus_valid_n) begin
					gnt_n_nxt = '1;
					rel_n_nxt = 1'b0;
					rn_nxt = cmd_rn(bus.system_command);
					got_nxt = '0;
					got_nxt[mst_r] = 1'b1;
					own_f_nxt = 1'b0;
					// peers snoop only in target mode
					if (snoop_mode
						&& is_coh(to_ext(cmd_op(bus.system_command)))) begin
						c_nxt = C_COLLECT; // [R11]
					end else begin
						c_nxt = C_ACK;
					end
				end
			end
			C_COLLECT: begin
				for (int p = 0; p < NPROC; p++) begin
					if (!bus.state_val_n[p]) begin
						got_nxt[p] = 1'b1;
						if (bus.state_out[p] == modified_owned_state) begin
							own_f_nxt = 1'b1;
							own_nxt = ID_W'(p);
						end
					end
				end
				if (&got_nxt) begin
					if (own_f_nxt) begin
						gnt_n_nxt[own_nxt] = 1'b0; // [R8]
						c_nxt = C_DATA;
					end else begin
						c_nxt = C_ACK; // [R10]
					end
				end
			end
			C_DATA: begin
				if (!bus.bus_valid_n
					&& cmd_op(bus.system_command) == PR_DATA) begin
					gnt_n_nxt = '1;
					rel_n_nxt = 1'b0;
					c_nxt = C_ACK; // [R9]
				end
			end
			C_ACK: begin
				rv_n_nxt = 1'b0; // [R9] [R10]
				rsp_nxt = '0;
				rsp_nxt[1:0] = RSP_ACK;
				rsp_nxt[RSP_RN_LSB +: RN_W] = rn_r;
				rsp_nxt[RSP_ID_LSB +: ID_W] = mst_r;
				c_nxt = C_IDLE;
			end
			default: c_nxt = C_IDLE;
		endcase
		busy_nxt = (c_nxt != C_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			c_r <= C_IDLE;
			gnt_n_r <= '1;
			got_r <= '0;
			mst_r <= '0;
			rr_r <= '0;
			own_r <= '0;
			own_f_r <= 1'b0;
			rn_r <= '0;
			rel_n_r <= 1'b1;
			rv_n_r <= 1'b1;
			rsp_r <= '0;
			busy_r <= 1'b0;
		end else begin
			c_r <= c_nxt;
			gnt_n_r <= gnt_n_nxt;
			got_r <= got_nxt;
			mst_r <= mst_nxt;
			rr_r <= rr_nxt;
			own_r <= own_nxt;
			own_f_r <= own_f_nxt;
			rn_r <= rn_nxt;
			rel_n_r <= rel_n_nxt;
			rv_n_r <= rv_n_nxt;
			rsp_r <= rsp_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign bus.bus_grant_n = gnt_n_r;
	assign bus.bus_release_n = rel_n_r;
	assign bus.resp_val_n = rv_n_r;
	assign bus.resp = rsp_r;
	assign busy = busy_r;
	assign master_id = mst_r;
endmodule // cluster_coordinator

// file: cluster_bus_props.sv
// assertions on the shared cluster bus
`timescale 1ns/1ps
module cluster_bus_props import cluster_pkg::*; #(
	parameter int NPROC = MAX_PROC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [NPROC-1:0] bus_request_n,
	input wire logic [NPROC-1:0] bus_grant_n,
	input wire logic bus_release_n,
	input wire logic [NPROC-1:0] cmd_oe,
	input wire logic [RSP_W-1:0] resp,
	input wire logic resp_val_n,
	input wire logic [CMD_W-1:0] system_command,
	input wire logic bus_valid_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	property p_one_grant; $onehot0(~bus_grant_n); endproperty
	property p_one_drv; $onehot0(cmd_oe); endproperty
	property p_drv_gnt; (cmd_oe & bus_grant_n) == '0; endproperty
	property p_gnt_drv;
		$past(&bus_grant_n) && !(&bus_grant_n) |=> |cmd_oe;
	endproperty
	// the release pulse closes a tenure, so it must follow a live grant
	property p_rel;
		!bus_release_n |-> $past(|(~bus_grant_n)) && &bus_grant_n
			##1 bus_release_n;
	endproperty
	property p_req_gnt; |(~bus_request_n) |-> ##[0:60] |(~bus_grant_n);
	endproperty
	property p_ack; !resp_val_n |-> resp[1:0] == RSP_ACK ##1 resp_val_n;
	endproperty
	property p_cmd_ack;
		!bus_valid_n && system_command[3:0] != PR_DATA |-> ##[1:60] !resp_val_n;
	endproperty
	a_one_grant: assert property (p_one_grant) else $error("grant overlap");
	a_one_drv: assert property (p_one_drv) else $error("two drivers");
	a_drv_gnt: assert property (p_drv_gnt) else $error("drive ungranted");
	a_gnt_drv: assert property (p_gnt_drv) else $error("grant unused");
	a_rel: assert property (p_rel) else $error("bad release");
	a_req_gnt: assert property (p_req_gnt) else $error("request starved");
	a_ack: assert property (p_ack) else $error("bad response");
	a_cmd_ack: assert property (p_cmd_ack) else $error("no completion");
	c_data: cover property (!bus_valid_n && system_command[3:0] == PR_DATA);
	c_upg: cover property (!bus_valid_n && system_command[3:0] == PR_UPGRADE);
	c_rel: cover property (!bus_release_n);
endmodule // cluster_bus_props

// file: tb_cluster_bus_coordination.sv
// bench: four nodes and the coordinator joined on one cluster bus
`timescale 1ns/1ps
module tb_cluster_bus_coordination import cluster_pkg::*; ;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid [4], req_taken [4], req_done [4], observe_valid [4];
	logic blk_data_valid [4], lookup_valid [4], lookup_done [4];
	logic queue_full [4], busy, tgt_mode = 1'b1;
	logic [ID_W-1:0] master_id;
	proc_op_t req_op [4];
	logic [AD_W-1:0] req_addr [4], observe_addr [4], blk_data [4];
	logic [AD_W-1:0] lookup_addr [4], lookup_data [4], obs_ad [4], blk_v [4];
	logic [RN_W-1:0] done_num [4];
	ext_op_t observe_op [4], obs_op [4], lookup_op [4], lk_op [4];
	state_t lookup_state [4];
	logic [CMD_W-1:0] cmd_v;
	logic [AD_W-1:0] coh_q [$], look_q [4][$];
	int fails = 0, total_checks = 0, data_src;
	int obs_n [4], blk_n [4], st_n [4], delay [4];
	proc_op_t ops [8] = '{PR_RD_NC, PR_RD_WORD, PR_WR_BLK, PR_WR_WORD,
		PR_ELIM, PR_RD_SHD, PR_RD_EXC, PR_UPGRADE};
	ext_op_t exps [8] = '{XR_ALLOC, XR_ALLOC, XR_NOP, XR_NOP, XR_NOP,
		XR_INT_SHD, XR_INT_EXC, XR_INVAL};
	////////////////////////////////////////
	always #2.5 clk = ~clk;
	cluster_bus_if #(.NPROC(4)) cbus (.clk(clk));
	cluster_coordinator #(.NPROC(4)) u_cluster_coordinator (.clk(clk),
		.nrst(nrst), .bus(cbus.coord), .snoop_mode(tgt_mode), .busy(busy),
		.master_id(master_id));
	cluster_bus_props #(.NPROC(4)) u_cluster_bus_props (.clk(clk),
		.nrst(nrst), .bus_request_n(cbus.bus_request_n),
		.bus_grant_n(cbus.bus_grant_n), .bus_release_n(cbus.bus_release_n),
		.cmd_oe(cbus.cmd_oe), .resp(cbus.resp), .resp_val_n(cbus.resp_val_n),
		.system_command(cbus.system_command), .bus_valid_n(cbus.bus_valid_n));
	for (genvar i = 0; i < 4; i++) begin : g_node
		int wc = 0;
		logic hold = 1'b0;
		cluster_node #(.NPROC(4), .ID(i)) u_cluster_node (.clk(clk),
			.nrst(nrst), .bus(cbus.node),
			.coherent_request_target_mode(tgt_mode),
			.req_valid(req_valid[i]), .req_op(req_op[i]),
			.req_addr(req_addr[i]), .req_taken(req_taken[i]),
			.req_done(req_done[i]), .done_num(done_num[i]),
			.observe_valid(observe_valid[i]), .observe_op(observe_op[i]),
			.observe_addr(observe_addr[i]),
			.blk_data_valid(blk_data_valid[i]), .blk_data(blk_data[i]),
			.lookup_valid(lookup_valid[i]), .lookup_op(lookup_op[i]),
			.lookup_addr(lookup_addr[i]), .lookup_done(lookup_done[i]),
			.lookup_state(lookup_state[i]), .lookup_data(lookup_data[i]),
			.queue_full(queue_full[i]));
		// cache stand-in: a delay of at least one rides out a stale valid
		always @(negedge clk) begin
			if (hold || !lookup_valid[i]) begin
				hold = 1'b0;
				wc = 0;
			end else if (wc < delay[i]) wc++;
			else begin
				hold = 1'b1;
				look_q[i].push_back(lookup_addr[i]);
				lk_op[i] = lookup_op[i];
			end
			lookup_done[i] = hold;
		end
		always @(posedge clk) begin
			if (observe_valid[i]) begin
				obs_n[i]++;
				obs_op[i] = observe_op[i];
				obs_ad[i] = observe_addr[i];
			end
			if (blk_data_valid[i]) begin
				blk_n[i]++;
				blk_v[i] = blk_data[i];
			end
			if (!cbus.state_val_n[i]) st_n[i]++;
			if (cbus.cmd_oe[i] && cbus.system_command[3:0] == PR_DATA) data_src = i;
		end
	end
	always @(posedge clk) if (!cbus.bus_valid_n && cbus.cmd_oe != '0
		&& cbus.system_command[3:0] != PR_DATA) begin
		cmd_v = cbus.system_command;
		if (cmd_v[3:0] inside {PR_RD_SHD, PR_RD_EXC, PR_UPGRADE})
			coh_q.push_back(cbus.system_addr_data);
	end
	////////////////////////////////////////
	task automatic check(input string what, input logic [AD_W-1:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic raise(input int n, input proc_op_t op,
		input logic [AD_W-1:0] a);
		@(negedge clk);
		req_valid[n] = 1'b1;
		req_op[n] = op;
		req_addr[n] = a;
		for (int t = 0; t < 40 && req_taken[n] !== 1'b1; t++) @(negedge clk);
		req_valid[n] = 1'b0;
		for (int t = 0; t < 80 && req_done[n] !== 1'b1; t++) @(negedge clk);
		check("req_done", 1, req_done[n]);
	endtask
	task automatic run(input int n, input int k, input int owner);
		logic [AD_W-1:0] a;
		a = 64'h0000_0040_0000_1000 + 64'(k * 64 + n);
		for (int p = 0; p < 4; p++) begin
			obs_n[p] = 0;
			blk_n[p] = 0;
			st_n[p] = 0;
			lookup_state[p] = p == owner ? modified_owned_state
				: k == 7 ? ST_SHARED : ST_INVALID;
		end
		data_src = -1;
		raise(n, ops[k], a);
		repeat (4) @(negedge clk);
		check("done_num", cmd_v[6:4], done_num[n]);
		check("cmd source", n, cmd_v[9:8]);
		check("data source", owner, data_src);
		for (int p = 0; p < 4; p++) begin
			check("observe count", p != n, obs_n[p]);
			if (p != n) check("observe_op", exps[k], obs_op[p]);
			if (p != n) check("observe_addr", a, obs_ad[p]);
			check("state count", p != n && k > 4 && tgt_mode, st_n[p]);
			if (p != n && k > 4 && tgt_mode)
				check("lookup_op", exps[k], lk_op[p]);
			check("queue_full", 0, queue_full[p]);
			check("data count", owner >= 0 && p != owner, blk_n[p]);
			if (owner >= 0 && p != owner)
				check("blk_data", lookup_data[owner], blk_v[p]);
		end
		check("master_id", n, master_id);
		check("busy", 0, busy);
		$display("test op %0d from node %0d done", k, n);
	endtask
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		for (int p = 0; p < 4; p++) begin
			req_valid[p] = 1'b0;
			req_op[p] = PR_NONE;
			req_addr[p] = '0;
			lookup_done[p] = 1'b0;
			lookup_state[p] = ST_INVALID;
			lookup_data[p] = 64'hda7a_0000_0000_0000 + 64'(p);
			delay[p] = 2;
		end
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		for (int k = 0; k < 5; k++) run(k % 3, k, -1);
		run(0, 6, 2);
		run(1, 5, 3);
		run(2, 7, -1);
		run(1, 5, -1);
		delay[3] = 6;
		fork
			raise(0, PR_RD_SHD, 64'h0000_0000_0000_0a00);
			raise(1, PR_UPGRADE, 64'h0000_0000_0000_0b00);
		join
		repeat (10) @(negedge clk);
		check("lookup count", coh_q.size(), look_q[3].size());
		foreach (coh_q[j]) if (j < look_q[3].size())
			check("lookup order", coh_q[j], look_q[3][j]);
		$display("test queued snoops done");
		// both ends leave target mode: peers observe but never snoop
		tgt_mode = 1'b0;
		run(3, 6, -1);
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("unexpected timeout: expected finish, seen hang");
		finish_test();
	end
endmodule // tb_cluster_bus_coordination
